/* File: dv/acq_checker.sv */
// Assertions on the acquisition block's bus, trigger and sequence outputs
`timescale 1ns/1ns
module acq_checker (
	input wire logic          hclk,
	input wire logic          hresetn,
	input wire logic          hsel,
	input wire logic [31:0]   haddr,
	input wire logic [1:0]    htrans,
	input wire logic          hwrite,
	input wire logic [2:0]    hsize,
	input wire logic [31:0]   hwdata,
	input wire logic          hready,
	input wire logic [31:0]   hrdata,
	input wire logic          hreadyout,
	input wire logic          hresp,
	input wire acq_pkg::adc_t adc,
	input wire logic          trig_in,
	input wire logic          trig_out,
	input wire logic          armed_indicator,
	input wire logic          seq_end,
	input wire logic          proc_busy
);
	import acq_pkg::*;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Trigger edge taken while armed, with a sample slot present
	sequence trig_taken;
		armed_indicator && $rose(trig_in) && adc.valid;
	endsequence
	// Sample window read, which costs exactly one wait cycle
	sequence slow_read;
		hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ofs_rd_data;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	trig_prompt_a: assert property (trig_taken |=> trig_out)
		else $error("trigger output late");
	trig_pulse_a: assert property (trig_out |=> !trig_out)
		else $error("trigger output too long");
	armed_drop_a: assert property (trig_taken |=> !armed_indicator)
		else $error("armed flag kept after trigger");
	trig_unarmed_a: assert property (trig_out |-> !armed_indicator)
		else $error("armed flag during trigger");
	end_pulse_a: assert property (seq_end |=> !seq_end)
		else $error("sequence end too long");
	read_wait_a: assert property (slow_read |=> one_wait)
		else $error("sample read wait wrong");
	wait_once_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state too long");
	upper_zero_a: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
		else $error("sample read upper bits set");
endmodule

bind dual_bank_sequence_acquisition acq_checker u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .adc, .trig_in, .trig_out, .armed_indicator,
	.seq_end, .proc_busy
);

/* File: dv/acq_source.sv */
// Sample stream and trigger source standing in for the front end
`timescale 1ns/1ns
module acq_source (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic gaps,
	input  wire logic fire,
	output acq_pkg::adc_t adc,
	output logic      trig_in
);
	import acq_pkg::*;
	logic [7:0] cnt;
	// Ramp advances every clock so each slot has a known value
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 8'h00;
			trig_in <= 1'b0;
		end else begin
			cnt <= cnt + 8'h01;
			trig_in <= fire;
		end
	end
	// Empty slots carry the inverse so stale data never looks valid
	assign adc.valid = !gaps || cnt[0];
	assign adc.data = adc.valid ? cnt : ~cnt;
endmodule

/* File: dv/test_dual_bank_sequence_acquisition.sv */
// Self-checking bench for the sequence acquisition block
`timescale 1ns/1ns
module test_dual_bank_sequence_acquisition;
	import acq_pkg::*;
	localparam logic [15:0] dly = 16'h0002;
	logic          hclk = 1'b0;
	logic          hresetn = 1'b0;
	logic          hsel = 1'b0;
	logic          hwrite = 1'b0;
	logic          gaps = 1'b0;
	logic          fire = 1'b0;
	logic [31:0]   haddr = 32'h0;
	logic [31:0]   hwdata = 32'h0;
	logic [1:0]    htrans = 2'h0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   hrdata;
	logic          hreadyout, hresp, trig_in, trig_out;
	logic          armed_indicator, seq_end, proc_busy;
	wire           hready;
	acq_pkg::adc_t adc;
	logic [7:0]    fs[$];
	logic [7:0]    s0;
	int            n_errors = 0;
	int            cmp_count = 0;
	int            bc = 0;
	int            blen = 0;
	assign hready = hreadyout;
	always #4 hclk = ~hclk;
	dual_bank_sequence_acquisition u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .adc,
		.trig_in, .trig_out, .armed_indicator, .seq_end, .proc_busy);
	acq_source u_src (.hclk, .hresetn, .gaps, .fire, .adc, .trig_in);
	// First stored sample of a segment follows trig_out by the delay plus two
	always @(posedge hclk) begin
		if (trig_out === 1'b1 && !gaps)
			fs.push_back(adc.data + dly[7:0] + 8'h02);
		if (proc_busy === 1'b1)
			bc++;
		else if (bc != 0) begin
			blen = bc;
			bc = 0;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("errors %0d, comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bounded wait for a level at a clock edge; a hang ends the run
	task automatic await(ref logic f, input logic v, input int lim, output int n);
		n = 0;
		@(posedge hclk);
		while (f !== v && n < lim) begin
			n++;
			@(posedge hclk);
		end
		if (f !== v) begin
			n_errors++;
			print_verdict;
		end
	endtask
	// Single AHB transfers; the master holds each phase until hready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		haddr <= {24'h0, a};
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		await(hreadyout, 1'b1, 20, n);
		htrans <= 2'b00;
		hwdata <= d;
		await(hreadyout, 1'b1, 20, n);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		xfer(1'b0, a, 32'h0, r);
	endtask
	// Trigger pulse from the source, then wait for the trigger output
	task automatic trig;
		int n;
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		await(trig_out, 1'b1, 10, n);
	endtask
	task automatic t_reset;
		logic [31:0] v;
		check({31'h0, armed_indicator}, 32'h0);
		rd(ofs_ctrl, v);
		check(v, {24'h0, ctrl_rst});
		rd(8'h30, v);
		check(v, 32'h0);
	endtask
	// Three segments, explicit mode; count times length well inside a bank
	task automatic t_seq;
		logic [31:0] v;
		int n;
		wr(ofs_ctrl, 32'h09);
		wr(ofs_seg_len, 32'h4);
		wr(ofs_seg_count, 32'h3);
		wr(ofs_start_delay, {16'h0, dly});
		wr(ofs_cmd, 32'h1);
		for (int k = 0; k < 3; k++) begin
			await(armed_indicator, 1'b1, 200, n);
			check({31'h0, n < int'(dead_time_cyc)}, 32'h1);
			trig();
		end
		await(seq_end, 1'b1, 50, n);
		rd(ofs_seg_done, v);
		check(v, 32'h3);
		rd(ofs_status, v);
		check({31'h0, v[stat_done]}, 32'h1);
		check({31'h0, armed_indicator}, 32'h0);
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (8) @(posedge hclk);
		rd(ofs_seg_done, v);
		check(v, 32'h3);
		wr(ofs_rd_sel, 32'h0);
		s0 = fs[0];
		for (int k = 0; k < 12; k++) begin
			rd(ofs_rd_data, v);
			check(v, {24'h0, fs[k / 4] + 8'(k % 4)});
		end
		// Gate of two samples from offset one in each segment
		wr(ofs_ctrl, 32'h89);
		wr(ofs_gate_start, 32'h1);
		wr(ofs_gate_len, 32'h2);
		wr(ofs_rd_sel, 32'h0);
		for (int k = 0; k < 4; k++) begin
			rd(ofs_rd_data, v);
			check(v, {24'h0, fs[k / 2] + 8'(k % 2 + 1)});
		end
		wr(ofs_ctrl, 32'h09);
		fs.delete();
	endtask
	// Single shot into bank one while bank zero is read out
	task automatic t_explicit;
		logic [31:0] v;
		int n;
		wr(ofs_seg_count, 32'h1);
		wr(ofs_bank_sel, 32'h1);
		wr(ofs_cmd, 32'h1);
		await(armed_indicator, 1'b1, 20, n);
		trig();
		wr(ofs_rd_sel, 32'h0);
		rd(ofs_rd_data, v);
		check(v, {24'h0, s0});
		check({31'h0, hresp}, 32'h0);
		await(seq_end, 1'b1, 50, n);
		wr(ofs_rd_sel, 32'h1);
		rd(ofs_rd_data, v);
		check(v, {24'h0, fs[0]});
	endtask
	// Autoswitch with early permission and automatic processing
	task automatic t_auto;
		logic [31:0] v;
		int n;
		wr(ofs_ctrl, 32'h3d);
		wr(ofs_cmd, 32'h1);
		wr(ofs_cmd, 32'h2);
		await(armed_indicator, 1'b1, 20, n);
		trig();
		await(seq_end, 1'b1, 50, n);
		await(armed_indicator, 1'b1, 20, n);
		check({31'h0, armed_indicator}, 32'h1);
		rd(ofs_status, v);
		check({30'h0, v[stat_bank], v[stat_permit]}, 32'h0);
		check(32'(blen), 32'h2);
		wr(ofs_cmd, 32'h8);
		fs.delete();
	endtask
	// Processing disabled finishes at once without running
	task automatic t_nop;
		logic [31:0] v;
		wr(ofs_ctrl, 32'h09);
		wr(ofs_status, 32'h10);
		blen = 0;
		wr(ofs_cmd, 32'h4);
		repeat (4) @(posedge hclk);
		rd(ofs_status, v);
		check({31'h0, v[stat_proc_done]}, 32'h1);
		check(32'(blen), 32'h0);
	endtask
	// Realigned trigger with sparse sample slots
	task automatic t_resync;
		logic [31:0] v;
		int n;
		gaps <= 1'b1;
		wr(ofs_ctrl, 32'h03);
		wr(ofs_seg_count, 32'h0);
		wr(ofs_cmd, 32'h1);
		await(armed_indicator, 1'b1, 20, n);
		trig();
		await(seq_end, 1'b1, 50, n);
		rd(ofs_seg_done, v);
		check(v, 32'h1);
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_seq();
		t_explicit();
		t_auto();
		t_nop();
		t_resync();
		print_verdict();
	end
endmodule

/* File: include/acq_pkg.sv */
// Shared constants, states and carriers for the sequence acquisition block
package acq_pkg;
	// Timing: sample clock rate, rearm budget and processing throughput
	localparam int unsigned clk_mhz        = 125;
	localparam int unsigned dead_time_ns   = 800;
	localparam int unsigned dead_time_cyc  = dead_time_ns * clk_mhz / 1000;
	localparam int unsigned proc_rate_msps = 260;

	// Widths
	localparam int unsigned sample_w = 8;
	localparam int unsigned bank_aw  = 15;
	localparam int unsigned nb_aw    = 18;
	localparam int unsigned addr_w   = 19;
	localparam int unsigned len_w    = 16;
	localparam int unsigned cnt_w    = 15;
	localparam int unsigned dly_w    = 16;

	// Samples consumed per clock by the processing step (rounded down)
	localparam logic [addr_w-1:0] proc_step = addr_w'(proc_rate_msps / clk_mhz);

	// Capacities and segment limits
	localparam logic [addr_w-1:0] bank_words     = 19'h08000;
	localparam logic [addr_w-1:0] nb_cap_single  = 19'h40000;
	localparam logic [addr_w-1:0] nb_cap_dual    = 19'h20000;
	localparam logic [cnt_w-1:0]  max_seg_two_ch = 15'h1fff;
	localparam logic [cnt_w-1:0]  max_seg_other  = 15'h4000;
	localparam logic [cnt_w-1:0]  max_seg_nb     = 15'h00c8;

	// Register byte offsets
	localparam logic [7:0] ofs_ctrl        = 8'h00;
	localparam logic [7:0] ofs_cmd         = 8'h04;
	localparam logic [7:0] ofs_seg_count   = 8'h08;
	localparam logic [7:0] ofs_seg_len     = 8'h0c;
	localparam logic [7:0] ofs_start_delay = 8'h10;
	localparam logic [7:0] ofs_bank_sel    = 8'h14;
	localparam logic [7:0] ofs_status      = 8'h18;
	localparam logic [7:0] ofs_seg_done    = 8'h1c;
	localparam logic [7:0] ofs_gate_start  = 8'h20;
	localparam logic [7:0] ofs_gate_len    = 8'h24;
	localparam logic [7:0] ofs_rd_sel      = 8'h28;
	localparam logic [7:0] ofs_rd_data     = 8'h2c;

	// Control register fields
	localparam int unsigned ctrl_enable    = 0;
	localparam int unsigned ctrl_resync    = 1;
	localparam int unsigned ctrl_autosw    = 2;
	localparam int unsigned ctrl_buffered  = 3;
	localparam int unsigned ctrl_proc_en   = 4;
	localparam int unsigned ctrl_auto_proc = 5;
	localparam int unsigned ctrl_dual_ch   = 6;
	localparam int unsigned ctrl_gate_en   = 7;
	localparam logic [7:0]  ctrl_rst       = 8'h08;

	// Command register fields (write one to act)
	localparam int unsigned cmd_start  = 0;
	localparam int unsigned cmd_permit = 1;
	localparam int unsigned cmd_proc   = 2;
	localparam int unsigned cmd_stop   = 3;

	// Status register fields
	localparam int unsigned stat_armed     = 0;
	localparam int unsigned stat_busy      = 1;
	localparam int unsigned stat_done      = 2;
	localparam int unsigned stat_proc_busy = 3;
	localparam int unsigned stat_proc_done = 4;
	localparam int unsigned stat_permit    = 5;
	localparam int unsigned stat_bank      = 6;

	// Readout source select fields
	localparam int unsigned rsel_bank   = 0;
	localparam int unsigned rsel_nonbuf = 1;

	typedef enum logic [3:0] {
		s_idle    = 4'b0001,
		s_armed   = 4'b0010,
		s_delay   = 4'b0100,
		s_capture = 4'b1000
	} acq_state_t;

	typedef enum logic [1:0] {
		p_idle = 2'b01,
		p_run  = 2'b10
	} proc_state_t;

	typedef enum logic [2:0] {
		t_idle  = 3'b001,
		t_align = 3'b010,
		t_count = 3'b100
	} trig_state_t;

	typedef struct packed {
		logic                valid;
		logic [sample_w-1:0] data;
	} adc_t;

	typedef struct packed {
		logic                we;
		logic [addr_w-1:0]   addr;
		logic [sample_w-1:0] data;
	} mem_wr_t;
endpackage

/* File: rtl/dual_bank_sequence_acquisition.sv */
// Dual-bank sequence acquisition sequencer with AHB-Lite registers
//
// Operation
// R1: Free trigger mode starts the delay at once, unaligned to samples.
// R2: Resync mode aligns the trigger to the next sample strobe.
// R3: Trigger gives an output pulse and starts capture after the delay.
// R4: Segment count programmable 1..8191 or 1..16384 by variant.
// R5: Every segment of a sequence has the same programmed length.
// R6: Host keeps count times length within installed memory.
// R7: A single acquisition is a sequence with count one.
// R8: Digitizer mode uses separate memory, 128K or 256K, 200 segments.
// R9: Trigger rearms between segments well within 800 ns.
// R10: Buffered mode writes a whole sequence into one bank.
// R11: Acquisition ends once the programmed segment count is captured.
// R12: Autoswitch with permission restarts at once and starts processing.
// R13: Host starts first acquisition and grants permission right away.
// R14: End of sequence is reported to the host.
// R15: Explicit mode host switches bank, restarts, then reads out.
// R16: Readout of the filled bank runs during capture into the other.
// R17: Readout may be limited to a gate within each segment.
// R18: Processing runs automatically after each sequence or on host command; code auto-starts only on autoswitch restarts with ctrl_auto_proc.
// R19: Processing ends at once when disabled, else runs at about 260 MS/s.
// R20: Armed indicator high when armed, low on trigger, busy or disabled.
// R21: Segments sit back to back at segment-length steps in capture order.
//
// Design decisions made here: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module dual_bank_sequence_acquisition #(
	parameter bit two_ch_variant = 1'b0
) (
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire logic           hsel,
	input  wire logic [31:0]    haddr,
	input  wire logic [1:0]     htrans,
	input  wire logic           hwrite,
	input  wire logic [2:0]     hsize,
	input  wire logic [31:0]    hwdata,
	input  wire logic           hready,
	output logic      [31:0]    hrdata,
	output logic                hreadyout,
	output logic                hresp,
	input  wire acq_pkg::adc_t  adc,
	input  wire logic           trig_in,
	output logic                trig_out,
	output logic                armed_indicator,
	output logic                seq_end,
	output logic                proc_busy
);
	import acq_pkg::*;

	// Only word offsets inside the map are decoded
	function automatic logic mapped(input logic [7:0] ofs);
		mapped = (ofs[1:0] == 2'b00) && (ofs <= ofs_rd_data);
	endfunction

	// Clamp requested segment count to the mode limit; zero means one
	function automatic logic [cnt_w-1:0] clamp_count(
		input logic [cnt_w-1:0] req,
		input logic             buffered
	);
		logic [cnt_w-1:0] lim;
		lim = buffered ? (two_ch_variant ? max_seg_two_ch : max_seg_other) : max_seg_nb;
		if (req == '0) begin
			clamp_count = cnt_w'(1); // [R7]
		end else if (req > lim) begin
			clamp_count = lim; // [R4] [R8]
		end else begin
			clamp_count = req;
		end
	endfunction

	// Bus front end
	logic             wr_pend;
	logic [7:0]       wr_ofs;
	logic             rd_wait;
	logic [31:0]      rmux;
	logic             take;

	// Software registers
	logic [7:0]       ctrl;
	logic [cnt_w-1:0] seg_count;
	logic [len_w-1:0] seg_len;
	logic [dly_w-1:0] post_trigger_clock_delay;
	logic             bank_sel;
	logic [len_w-1:0] gate_start;
	logic [len_w-1:0] gate_len;
	logic [1:0]       rd_sel;
	logic [len_w-1:0] rd_idx;
	logic [addr_w-1:0] rd_base;
	logic             done_flag;
	logic             proc_done_flag;
	logic             permit;

	// Capture state
	acq_state_t        state;
	proc_state_t       pstate;
	logic              bank;
	logic              run_buf;
	logic [cnt_w-1:0]  run_count;
	logic [cnt_w-1:0]  seg_idx;
	logic [len_w-1:0]  samp_idx;
	logic [addr_w-1:0] wr_base;
	logic [addr_w-1:0] filled_total;
	logic [addr_w-1:0] p_left;
	logic              trig_prev;

	// Derived strobes
	logic              wr_reg;
	logic              cmd_wr;
	logic              trig_rise;
	logic              clk_start;
	logic              seg_last;
	logic              end_evt;
	logic              chain;
	logic              proc_start;
	logic              proc_fin;
	logic [len_w-1:0]  eff_len;
	logic [len_w-1:0]  eff_gstart;
	logic [len_w-1:0]  eff_glen;
	logic [addr_w-1:0] wr_addr;
	logic [addr_w-1:0] cap;
	logic [addr_w-1:0] rd_addr;
	logic [sample_w-1:0] bank_rdata;
	logic [sample_w-1:0] nb_rdata;
	logic [sample_w-1:0] rd_data;
	mem_wr_t           bank_wr;
	mem_wr_t           nb_wr;

	assign take   = hsel && htrans[1] && hready;
	assign wr_reg = wr_pend && mapped(wr_ofs);
	assign cmd_wr = wr_reg && (wr_ofs == ofs_cmd);

	// Zero length is read as one sample; length is taken live from seg_len, not latched at sequence start
	assign eff_len    = (seg_len == '0) ? len_w'(1) : seg_len; // [R5]
	assign eff_gstart = ctrl[ctrl_gate_en] ? gate_start : '0;
	assign eff_glen   = ctrl[ctrl_gate_en] ? gate_len : eff_len; // [R17]

	// Capture bookkeeping
	assign trig_rise = trig_in && !trig_prev && (state == s_armed);
	assign seg_last  = (state == s_capture) && adc.valid && (samp_idx == eff_len - 1'b1);
	assign end_evt   = seg_last && (seg_idx + 1'b1 == run_count); // [R11]
	assign chain     = end_evt && ctrl[ctrl_autosw] && permit; // [R12]
	assign wr_addr   = wr_base + addr_w'(samp_idx); // [R21]
	assign cap       = run_buf ? bank_words : (ctrl[ctrl_dual_ch] ? nb_cap_dual : nb_cap_single);

	// Writes past capacity are dropped rather than wrapping over old data
	always_comb begin
		bank_wr      = '0;
		nb_wr        = '0;
		bank_wr.addr = {3'h0, bank, wr_addr[bank_aw-1:0]}; // [R10]
		bank_wr.data = adc.data;
		nb_wr.addr   = wr_addr;
		nb_wr.data   = adc.data;
		if ((state == s_capture) && adc.valid && (wr_addr < cap)) begin
			bank_wr.we = run_buf;
			nb_wr.we   = !run_buf; // [R8]
		end
	end

	trig_start_delay u_trig (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.trig          (trig_rise),
		.resync        (ctrl[ctrl_resync]),
		.sample_strobe (adc.valid),
		.delay         (post_trigger_clock_delay),
		.trig_out      (trig_out),
		.clk_start     (clk_start)
	);

	sample_ram #(.aw(bank_aw + 1), .dw(sample_w)) u_bank_ram (
		.clk   (hclk),
		.we    (bank_wr.we),
		.waddr (bank_wr.addr[bank_aw:0]),
		.wdata (bank_wr.data),
		.raddr ({rd_sel[rsel_bank], rd_addr[bank_aw-1:0]}), // [R16]
		.rdata (bank_rdata)
	);

	sample_ram #(.aw(nb_aw), .dw(sample_w)) u_nb_ram (
		.clk   (hclk),
		.we    (nb_wr.we),
		.waddr (nb_wr.addr[nb_aw-1:0]),
		.wdata (nb_wr.data),
		.raddr (rd_addr[nb_aw-1:0]),
		.rdata (nb_rdata)
	);

	assign rd_addr = rd_base + addr_w'(eff_gstart) + addr_w'(rd_idx); // [R17]
	assign rd_data = rd_sel[rsel_nonbuf] ? nb_rdata : bank_rdata;

	// Read decode; reads of the data port take one wait state
	always_comb begin
		rmux = '0;
		if (mapped(haddr[7:0])) begin
			case (haddr[7:0])
				ofs_ctrl:        rmux = 32'(ctrl);
				ofs_seg_count:   rmux = 32'(seg_count);
				ofs_seg_len:     rmux = 32'(seg_len);
				ofs_start_delay: rmux = 32'(post_trigger_clock_delay);
				ofs_bank_sel:    rmux = 32'(bank_sel);
				ofs_status:      rmux = 32'({bank, permit, proc_done_flag, proc_busy,
					done_flag, (state != s_idle), armed_indicator});
				ofs_seg_done:    rmux = 32'(seg_idx);
				ofs_gate_start:  rmux = 32'(gate_start);
				ofs_gate_len:    rmux = 32'(gate_len);
				ofs_rd_sel:      rmux = 32'(rd_sel);
				default:         rmux = '0;
			endcase
		end
	end

	// AHB-Lite slave: writes land in the data phase, reads are registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			wr_ofs    <= 8'h00;
			rd_wait   <= 1'b0;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= take && hwrite;
			rd_wait   <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (take) begin
				wr_ofs <= haddr[7:0];
			end
			if (rd_wait) begin
				hrdata <= 32'(rd_data);
			end else if (take && !hwrite) begin
				hrdata <= rmux;
				if (haddr[7:0] == ofs_rd_data) begin
					hreadyout <= 1'b0;
					rd_wait   <= 1'b1;
				end
			end
		end
	end

	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl                     <= ctrl_rst;
			seg_count                <= '0;
			seg_len                  <= '0;
			post_trigger_clock_delay <= '0;
			bank_sel                 <= 1'b0;
			gate_start               <= '0;
			gate_len                 <= '0;
		end else if (wr_reg) begin
			case (wr_ofs)
				ofs_ctrl:        ctrl <= hwdata[7:0];
				ofs_seg_count:   seg_count <= hwdata[cnt_w-1:0]; // [R4]
				ofs_seg_len:     seg_len <= hwdata[len_w-1:0];
				ofs_start_delay: post_trigger_clock_delay <= hwdata[dly_w-1:0];
				ofs_bank_sel:    bank_sel <= hwdata[0]; // [R15]
				ofs_gate_start:  gate_start <= hwdata[len_w-1:0];
				ofs_gate_len:    gate_len <= hwdata[len_w-1:0];
				default:         ctrl <= ctrl;
			endcase
		end
	end

	// Readout pointer walks the gate of each segment, then the next segment
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_sel  <= 2'b00;
			rd_idx  <= '0;
			rd_base <= '0;
		end else if (wr_reg && (wr_ofs == ofs_rd_sel)) begin
			rd_sel  <= hwdata[1:0];
			rd_idx  <= '0;
			rd_base <= '0;
		end else if (rd_wait) begin
			if (rd_idx + 1'b1 >= eff_glen) begin
				rd_idx  <= '0;
				rd_base <= rd_base + addr_w'(eff_len); // [R17] [R21]
			end else begin
				rd_idx <= rd_idx + 1'b1;
			end
		end
	end

	// Sticky flags; a hardware set wins over a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_flag      <= 1'b0;
			proc_done_flag <= 1'b0;
			permit         <= 1'b0;
		end else begin
			done_flag <= end_evt ||
				(done_flag && !(wr_reg && wr_ofs == ofs_status && hwdata[stat_done])); // [R14]
			proc_done_flag <= proc_fin ||
				(proc_done_flag && !(wr_reg && wr_ofs == ofs_status && hwdata[stat_proc_done]));
			permit <= (cmd_wr && hwdata[cmd_permit]) || (permit && !chain); // [R13]
		end
	end

	// Sequence state machine; rearm takes one clock, far below the dead-time budget
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state        <= s_idle;
			bank         <= 1'b0;
			run_buf      <= 1'b0;
			run_count    <= '0;
			seg_idx      <= '0;
			samp_idx     <= '0;
			wr_base      <= '0;
			filled_total <= '0;
			seq_end      <= 1'b0;
			trig_prev    <= 1'b0;
		end else begin
			trig_prev <= trig_in;
			seq_end   <= end_evt; // [R14]
			case (state)
				s_idle: begin
					if (cmd_wr && hwdata[cmd_start] && ctrl[ctrl_enable]) begin
						bank      <= bank_sel; // [R10] [R15]
						run_buf   <= ctrl[ctrl_buffered];
						run_count <= clamp_count(seg_count, ctrl[ctrl_buffered]); // [R7]
						seg_idx   <= '0;
						wr_base   <= '0;
						state     <= s_armed;
					end
				end
				s_armed: begin
					if (!ctrl[ctrl_enable] || (cmd_wr && hwdata[cmd_stop])) begin
						state <= s_idle;
					end else if (trig_rise) begin
						state <= s_delay;
					end
				end
				s_delay: begin
					if (cmd_wr && hwdata[cmd_stop]) begin
						state <= s_idle;
					end else if (clk_start) begin
						samp_idx <= '0;
						state    <= s_capture; // [R3]
					end
				end
				s_capture: begin
					if (cmd_wr && hwdata[cmd_stop]) begin
						state <= s_idle;
					end else if (adc.valid) begin
						samp_idx <= samp_idx + 1'b1;
						if (seg_last) begin
							samp_idx <= '0;
							seg_idx  <= seg_idx + 1'b1;
							wr_base  <= wr_base + addr_w'(eff_len); // [R21]
							state    <= s_armed; // [R9]
						end
						if (end_evt) begin
							filled_total <= wr_base + addr_w'(eff_len);
							state        <= s_idle; // [R11]
							if (chain) begin
								bank    <= !bank; // [R12]
								seg_idx <= '0;
								wr_base <= '0;
								state   <= s_armed;
							end
						end
					end
				end
				default: begin
					state <= s_idle;
				end
			endcase
		end
	end

	// Armed indicator falls in the same edge that sees the trigger
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_indicator <= 1'b0;
		end else begin
			armed_indicator <= (state == s_armed) && ctrl[ctrl_enable] && !trig_rise; // [R20]
		end
	end

	// Processing: chained after autoswitch or started by the host
	assign proc_start = (chain && ctrl[ctrl_auto_proc]) || (cmd_wr && hwdata[cmd_proc]); // [R18]
	assign proc_fin   = (pstate == p_idle && proc_start && !ctrl[ctrl_proc_en]) ||
		(pstate == p_run && p_left <= proc_step); // [R19]

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pstate    <= p_idle;
			p_left    <= '0;
			proc_busy <= 1'b0;
		end else begin
			case (pstate)
				p_idle: begin
					if (proc_start && ctrl[ctrl_proc_en]) begin
						p_left    <= end_evt ? wr_base + addr_w'(eff_len) : filled_total;
						proc_busy <= 1'b1;
						pstate    <= p_run; // [R18]
					end
				end
				p_run: begin
					if (p_left <= proc_step) begin
						proc_busy <= 1'b0;
						pstate    <= p_idle;
					end else begin
						p_left <= p_left - proc_step; // [R19]
					end
				end
				default: begin
					pstate <= p_idle;
				end
			endcase
		end
	end
endmodule

/* File: rtl/sample_ram.sv */
// Simple dual-port sample memory with registered read data
`timescale 1ns/1ns
module sample_ram #(
	parameter int unsigned aw = 15,
	parameter int unsigned dw = 8
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [aw-1:0] waddr,
	input  wire logic [dw-1:0] wdata,
	input  wire logic [aw-1:0] raddr,
	output logic      [dw-1:0] rdata
);
	logic [dw-1:0] mem [0:(1<<aw)-1];

	// Write and read ports are independent, so readout overlaps capture
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

/* File: rtl/trig_start_delay.sv */
// Trigger output pulse and delayed digitizing start
`timescale 1ns/1ns
module trig_start_delay (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     trig,
	input  wire logic                     resync,
	input  wire logic                     sample_strobe,
	input  wire logic [acq_pkg::dly_w-1:0] delay,
	output logic                          trig_out,
	output logic                          clk_start
);
	import acq_pkg::*;

	trig_state_t       state;
	logic [dly_w-1:0]  cnt;

	// Free mode acts at once; resync mode waits for the sample grid
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= t_idle;
			cnt       <= '0;
			trig_out  <= 1'b0;
			clk_start <= 1'b0;
		end else begin
			trig_out  <= 1'b0;
			clk_start <= 1'b0;
			case (state)
				t_idle: begin
					if (trig && (!resync || sample_strobe)) begin
						trig_out <= 1'b1; // [R1] [R3]
						cnt      <= delay;
						state    <= t_count;
					end else if (trig) begin
						state <= t_align; // [R2]
					end
				end
				t_align: begin
					if (sample_strobe) begin
						trig_out <= 1'b1; // [R2] [R3]
						cnt      <= delay;
						state    <= t_count;
					end
				end
				t_count: begin
					if (cnt == '0) begin
						clk_start <= 1'b1; // [R3]
						state     <= t_idle;
					end else begin
						cnt <= cnt - 1'b1;
					end
				end
				default: begin
					state <= t_idle;
				end
			endcase
		end
	end
endmodule
